/* hdl/arpt_pkg.sv */
package arpt_pkg;
	// Register map, by word index on the plain register port
	localparam int unsigned ADDR_W = 3;
	localparam logic [2:0] OFF_CSR = 3'h0;
	localparam logic [2:0] OFF_CAR = 3'h1;
	localparam logic [2:0] OFF_ARR = 3'h2;
	localparam logic [2:0] OFF_PWM = 3'h3;

	// Control and status field positions
	localparam int unsigned BIT_EXT_CLOCK_SELECT = 7;
	localparam int unsigned BIT_PSEL_HI = 6;
	localparam int unsigned BIT_PSEL_LO = 4;
	localparam int unsigned BIT_TCE = 3;
	localparam int unsigned BIT_FORCE_RELOAD = 2;
	localparam int unsigned BIT_OIE = 1;
	localparam int unsigned BIT_OVF = 0;

	// Values after reset
	localparam logic [7:0] CSR_RST = 8'h00;
	localparam logic [7:0] CAR_RST = 8'h00;
	localparam logic [7:0] ARR_RST = 8'h00;
	localparam logic [3:0] POL_RST = 4'h0;
	localparam logic [6:0] DIV_RST = 7'h00;

	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam int unsigned DIV_W = 7;
	localparam int unsigned N_PWM = 4;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} arpt_bus_t;
endpackage : arpt_pkg

/* hdl/arpt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module arpt_prescaler (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_tick,
	input wire logic run,
	input wire logic clear,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [arpt_pkg::DIV_W-1:0] div_ff;
	logic [arpt_pkg::DIV_W-1:0] mask;

	// Divide by two to the power sel
	assign mask = 7'((8'h01 << sel) - 8'h01); // [RULE_02]
	assign tick = run & in_tick & ~clear & ((div_ff & mask) == mask); // [RULE_02] [RULE_03]

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_ff <= arpt_pkg::DIV_RST;
		end else if (clear) begin
			div_ff <= arpt_pkg::DIV_RST; // [RULE_05]
		end else if (run && in_tick) begin
			div_ff <= 7'(div_ff + 7'h01); // [RULE_03]
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_div_by_one: assert property (run && in_tick && !clear && sel == 3'h0 |-> tick) // [RULE_02]
		else $error("prescaler skipped a tick at divide by one");
	chk_div_spacing: assert property (tick && sel != 3'h0 ##1 sel != 3'h0 |-> !tick) // [RULE_02]
		else $error("prescaler ticked twice in a row while dividing");
	chk_div_frozen: assert property (!run && !clear |=> $stable(div_ff)) // [RULE_03]
		else $error("prescaler moved while stopped");
endmodule : arpt_prescaler
`default_nettype wire

/* hdl/arpt_pwm_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module arpt_pwm_chan (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic level,
	output logic pwm_ff
);
	// Output takes its polarity level on each overflow reload
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pwm_ff <= 1'b0;
		end else if (load) begin
			pwm_ff <= level; // [RULE_11]
		end
	end
endmodule : arpt_pwm_chan
`default_nettype wire

/* hdl/arpt_timer.sv */
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE_01: Prescaler input is the CPU clock when ext_clock_select is 0, else external clock.
// RULE_02: prescale_select codes 0..7 divide the prescaler input by 1 up to 128.
// RULE_03: With count_enable low, prescaler and counter stay frozen; high lets them count.
// RULE_04: force_reload is write-only and always reads back as zero.
// RULE_05: Writing force_reload loads the reload value and clears the prescaler.
// RULE_06: Interrupt request follows overflow_flag only while overflow_irq_enable is set.
// RULE_07: overflow_flag is set when the counter wraps from FFh to the reload value.
// RULE_08: Reading the control and status register clears overflow_flag; writes never do.
// RULE_09: Count access register reads the live count; a write loads it while running.
// RULE_10: Every overflow loads the reload value into the counter.
// RULE_11: At each overflow reload, each PWM output takes its polarity bit.
// RULE_12: Reload value sets PWM period of 256 minus reload ticks.
// RULE_13: When enabled, counter increments by one per prescaler tick, overflowing after FFh.
// RULE_14: Reset clears all timer registers: counter stopped, CPU clock, divide by one.
module arpt_timer (
	input wire logic clk,
	input wire logic rst_b,
	input wire arpt_pkg::arpt_bus_t bus_i,
	input wire logic ext_clk_in,
	output logic [7:0] rdata_ff,
	output logic irq_ff,
	output logic [arpt_pkg::N_PWM-1:0] pwm_out
);
	// Control and status fields
	logic ext_clock_select_ff;
	logic [2:0] psel_ff;
	logic ten_ff;
	logic oie_ff;
	logic ovf_ff;
	logic nxt_ovf_ff;
	logic nxt_oie_ff;

	// Counter, reload and PWM polarity
	logic [7:0] cnt_ff;
	logic [7:0] reload_ff;
	logic [arpt_pkg::N_PWM-1:0] pol_ff;

	// External clock edge detection
	logic ext_prev_ff;
	logic ext_edge;
	logic in_tick;

	// Decoded accesses and events
	logic wr_csr;
	logic wr_car;
	logic wr_arr;
	logic wr_pwm;
	logic rd_csr;
	logic fr;
	logic tick;
	logic ovf_evt;
	logic [7:0] nxt_rdata_ff;

	assign wr_csr = bus_i.wr && bus_i.addr == arpt_pkg::OFF_CSR;
	assign wr_car = bus_i.wr && bus_i.addr == arpt_pkg::OFF_CAR;
	assign wr_arr = bus_i.wr && bus_i.addr == arpt_pkg::OFF_ARR;
	assign wr_pwm = bus_i.wr && bus_i.addr == arpt_pkg::OFF_PWM;
	assign rd_csr = bus_i.rd && bus_i.addr == arpt_pkg::OFF_CSR;
	assign fr = wr_csr && bus_i.wdata[arpt_pkg::BIT_FORCE_RELOAD]; // [RULE_05]

	// Input is taken synchronous, so a one-flop history suffices
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ext_prev_ff <= 1'b0;
		end else begin
			ext_prev_ff <= ext_clk_in;
		end
	end

	assign ext_edge = ext_clk_in & ~ext_prev_ff;
	assign in_tick = ext_clock_select_ff ? ext_edge : 1'b1; // [RULE_01]

	arpt_prescaler u_presc (
		.clk(clk),
		.rst_b(rst_b),
		.in_tick(in_tick),
		.run(ten_ff),
		.clear(fr),
		.sel(psel_ff),
		.tick(tick)
	);

	// A software load in the same cycle pre-empts the wrap
	assign ovf_evt = tick && cnt_ff == arpt_pkg::CNT_MAX && !fr && !wr_car; // [RULE_07]

	// Software-owned control fields
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ext_clock_select_ff <= arpt_pkg::CSR_RST[arpt_pkg::BIT_EXT_CLOCK_SELECT]; // [RULE_14]
			psel_ff <= arpt_pkg::CSR_RST[arpt_pkg::BIT_PSEL_HI:arpt_pkg::BIT_PSEL_LO];
			ten_ff <= arpt_pkg::CSR_RST[arpt_pkg::BIT_TCE];
			oie_ff <= arpt_pkg::CSR_RST[arpt_pkg::BIT_OIE];
		end else if (wr_csr) begin
			ext_clock_select_ff <= bus_i.wdata[arpt_pkg::BIT_EXT_CLOCK_SELECT]; // [RULE_01]
			psel_ff <= bus_i.wdata[arpt_pkg::BIT_PSEL_HI:arpt_pkg::BIT_PSEL_LO]; // [RULE_02]
			ten_ff <= bus_i.wdata[arpt_pkg::BIT_TCE]; // [RULE_03]
			oie_ff <= nxt_oie_ff;
		end
	end

	// Overflow flag: set wins over the read-clear
	always_comb begin
		nxt_oie_ff = wr_csr ? bus_i.wdata[arpt_pkg::BIT_OIE] : oie_ff;
		if (ovf_evt) begin
			nxt_ovf_ff = 1'b1; // [RULE_07]
		end else if (rd_csr) begin
			nxt_ovf_ff = 1'b0; // [RULE_08]
		end else begin
			nxt_ovf_ff = ovf_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ovf_ff <= arpt_pkg::CSR_RST[arpt_pkg::BIT_OVF];
			irq_ff <= 1'b0;
		end else begin
			ovf_ff <= nxt_ovf_ff;
			irq_ff <= nxt_ovf_ff & nxt_oie_ff; // [RULE_06]
		end
	end

	// Reload value and PWM polarity
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reload_ff <= arpt_pkg::ARR_RST; // [RULE_14]
		end else if (wr_arr) begin
			reload_ff <= bus_i.wdata; // [RULE_12]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pol_ff <= arpt_pkg::POL_RST;
		end else if (wr_pwm) begin
			pol_ff <= bus_i.wdata[arpt_pkg::N_PWM-1:0];
		end
	end

	// Counter: force reload, then software load, then tick
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_ff <= arpt_pkg::CAR_RST; // [RULE_14]
		end else if (fr) begin
			cnt_ff <= reload_ff; // [RULE_05]
		end else if (wr_car) begin
			cnt_ff <= bus_i.wdata; // [RULE_09]
		end else if (ovf_evt) begin
			cnt_ff <= reload_ff; // [RULE_10] [RULE_12]
		end else if (tick) begin
			cnt_ff <= 8'(cnt_ff + 8'h01); // [RULE_13]
		end
	end

	// Read mux, data valid in the cycle after the strobe
	always_comb begin
		case (bus_i.addr)
			arpt_pkg::OFF_CSR: begin
				nxt_rdata_ff = {ext_clock_select_ff, psel_ff, ten_ff, 1'b0, oie_ff, ovf_ff}; // [RULE_04]
			end
			arpt_pkg::OFF_CAR: begin
				nxt_rdata_ff = cnt_ff; // [RULE_09]
			end
			arpt_pkg::OFF_ARR: begin
				nxt_rdata_ff = reload_ff;
			end
			arpt_pkg::OFF_PWM: begin
				nxt_rdata_ff = {4'h0, pol_ff};
			end
			default: begin
				nxt_rdata_ff = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_ff <= 8'h00;
		end else if (bus_i.rd) begin
			rdata_ff <= nxt_rdata_ff;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// One output stage per PWM channel
	genvar gi;
	generate
		for (gi = 0; gi < arpt_pkg::N_PWM; gi++) begin : g_pwm
			arpt_pwm_chan u_chan (
				.clk(clk),
				.rst_b(rst_b),
				.load(ovf_evt), // [RULE_11]
				.level(pol_ff[gi]),
				.pwm_ff(pwm_out[gi])
			);
		end
	endgenerate

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_src_cpu: assert property (!ext_clock_select_ff |-> in_tick) // [RULE_01]
		else $error("CPU clock source did not tick every cycle");
	chk_src_ext: assert property (ext_clock_select_ff |-> in_tick == (ext_clk_in && !ext_prev_ff)) // [RULE_01]
		else $error("external source tick does not match an input rising edge");
	chk_count_frozen: assert property (!ten_ff && !fr && !wr_car |=> $stable(cnt_ff)) // [RULE_03]
		else $error("counter moved while counting was disabled");
	chk_force_reload_reads_zero: assert property (rd_csr |=> rdata_ff[arpt_pkg::BIT_FORCE_RELOAD] == 1'b0) // [RULE_04]
		else $error("force reload bit read back as one");
	chk_force_reload_loads: assert property (fr |=> cnt_ff == $past(reload_ff)) // [RULE_05]
		else $error("force reload did not load the reload value");
	chk_irq_gating: assert property (irq_ff == (ovf_ff && oie_ff)) // [RULE_06]
		else $error("interrupt request does not follow flag and enable");
	chk_ovf_sets: assert property (ovf_evt |=> ovf_ff ##0 cnt_ff == $past(reload_ff)) // [RULE_07]
		else $error("overflow did not set the flag with the reload value");
	chk_ovf_read_clear: assert property (rd_csr && !ovf_evt |=> !ovf_ff) // [RULE_08]
		else $error("status read did not clear the overflow flag");
	chk_ovf_write_keep: assert property (wr_csr && ovf_ff |=> ovf_ff) // [RULE_08]
		else $error("a write cleared the overflow flag");
	chk_car_load: assert property (wr_car && !fr |=> cnt_ff == $past(bus_i.wdata)) // [RULE_09]
		else $error("count access write did not load the counter");
	chk_car_read: assert property (bus_i.rd && bus_i.addr == arpt_pkg::OFF_CAR // [RULE_09]
		|=> rdata_ff == $past(cnt_ff))
		else $error("count access read did not return the live count");
	chk_auto_reload: assert property (ovf_evt |=> cnt_ff == $past(reload_ff)) // [RULE_10]
		else $error("overflow did not reload the counter");
	chk_pwm_level: assert property (ovf_evt |=> pwm_out == $past(pol_ff)) // [RULE_11]
		else $error("PWM outputs did not take their polarity at reload");
	chk_pwm_hold: assert property (!ovf_evt |=> $stable(pwm_out)) // [RULE_11]
		else $error("PWM outputs changed without a reload");
	chk_count_up: assert property (tick && cnt_ff != arpt_pkg::CNT_MAX // [RULE_13]
		&& !fr && !wr_car |=> cnt_ff == 8'($past(cnt_ff) + 8'h01))
		else $error("counter did not step by one on a tick");
	chk_reset_clear: assert property (disable iff (1'b0) !$past(rst_b) // [RULE_14]
		|-> cnt_ff == 8'h00 && reload_ff == 8'h00 && !ten_ff && !ext_clock_select_ff && psel_ff == 3'h0)
		else $error("reset left a timer register non-zero");

	// Software-owned fields move only on their own writes
	chk_ext_clock_select_write: assert property (wr_csr // [RULE_01]
		|=> ext_clock_select_ff == $past(bus_i.wdata[arpt_pkg::BIT_EXT_CLOCK_SELECT]))
		else $error("control write did not set the clock source");
	chk_ext_clock_select_hold: assert property (!wr_csr |=> $stable(ext_clock_select_ff)) // [RULE_01]
		else $error("clock source changed without a control write");
	chk_psel_write: assert property (wr_csr // [RULE_02]
		|=> psel_ff == $past(bus_i.wdata[arpt_pkg::BIT_PSEL_HI:arpt_pkg::BIT_PSEL_LO]))
		else $error("control write did not set the prescale code");
	chk_ten_write: assert property (wr_csr // [RULE_03]
		|=> ten_ff == $past(bus_i.wdata[arpt_pkg::BIT_TCE]))
		else $error("control write did not set the count enable");
	chk_oie_write: assert property (wr_csr // [RULE_06]
		|=> oie_ff == $past(bus_i.wdata[arpt_pkg::BIT_OIE]))
		else $error("control write did not set the interrupt enable");
	chk_arr_write: assert property (wr_arr // [RULE_12]
		|=> reload_ff == $past(bus_i.wdata))
		else $error("reload write did not land");
	chk_reload_hold: assert property (!wr_arr |=> $stable(reload_ff)) // [RULE_10]
		else $error("reload value changed without a write");
	chk_pol_write: assert property (wr_pwm // [RULE_11]
		|=> pol_ff == $past(bus_i.wdata[arpt_pkg::N_PWM-1:0]))
		else $error("polarity write did not land");
	chk_pol_hold: assert property (!wr_pwm |=> $stable(pol_ff)) // [RULE_11]
		else $error("polarity bits changed without a write");

	// Flag, interrupt and counter events
	chk_ovf_hold: assert property (!ovf_evt && !rd_csr |=> $stable(ovf_ff)) // [RULE_08]
		else $error("overflow flag moved without a wrap or a status read");
	chk_ovf_from_wrap: assert property ($rose(ovf_ff) |-> $past(ovf_evt)) // [RULE_07]
		else $error("overflow flag rose without a wrap");
	chk_wrap_at_max: assert property (ovf_evt |-> cnt_ff == arpt_pkg::CNT_MAX) // [RULE_07]
		else $error("wrap taken below the top count");
	chk_ovf_read_value: assert property (rd_csr // [RULE_08]
		|=> rdata_ff[arpt_pkg::BIT_OVF] == $past(ovf_ff))
		else $error("status read did not show the flag before clearing it");
	chk_irq_masked: assert property (!oie_ff |-> !irq_ff) // [RULE_06]
		else $error("interrupt request raised while disabled");
	chk_irq_on_wrap: assert property (ovf_evt && oie_ff && !wr_csr // [RULE_06]
		|=> irq_ff)
		else $error("enabled wrap did not raise the interrupt request");
	chk_tick_needs_run: assert property (tick |-> ten_ff) // [RULE_03]
		else $error("counter tick while counting was disabled");
	chk_force_reload_no_wrap: assert property (fr |-> !ovf_evt) // [RULE_05]
		else $error("wrap taken in a force reload cycle");
	chk_car_no_wrap: assert property (wr_car |-> !ovf_evt) // [RULE_09]
		else $error("wrap taken in a count write cycle");

	// Read port
	chk_rdata_idle: assert property (!bus_i.rd |=> rdata_ff == 8'h00) // [RULE_09]
		else $error("read data not zero outside a read");
	chk_arr_read: assert property (bus_i.rd && bus_i.addr == arpt_pkg::OFF_ARR // [RULE_12]
		|=> rdata_ff == $past(reload_ff))
		else $error("reload read did not return the reload value");
	chk_pwm_read: assert property (bus_i.rd && bus_i.addr == arpt_pkg::OFF_PWM // [RULE_11]
		|=> rdata_ff == {4'h0, $past(pol_ff)})
		else $error("polarity read did not return the polarity bits");

	cov_overflow: cover property (ovf_evt);
	cov_force_reload: cover property (fr && ten_ff);
	cov_irq: cover property (irq_ff ##1 rd_csr);
	cov_ext_overflow: cover property (ovf_evt && ext_clock_select_ff && psel_ff == 3'h0);
	cov_car_on_fly: cover property (wr_car && ten_ff);
endmodule : arpt_timer
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic w;
		logic [2:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} arpt_row_t;
	logic clk;
	logic rst_b;
	arpt_pkg::arpt_bus_t bus;
	logic ext_clk_in;
	logic [7:0] rdata_ff;
	logic irq_ff;
	logic [arpt_pkg::N_PWM-1:0] pwm_out;
	int fails;
	int compares;
	int n;
	logic [7:0] got;
	arpt_row_t rows [11];

	arpt_timer dut (
		.clk(clk),
		.rst_b(rst_b),
		.bus_i(bus),
		.ext_clk_in(ext_clk_in),
		.rdata_ff(rdata_ff),
		.irq_ff(irq_ff),
		.pwm_out(pwm_out)
	);

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
		@(posedge clk);
		bus.wr <= 1'h0;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
		@(posedge clk);
		bus.rd <= 1'h0;
		#1;
		v = rdata_ff;
	endtask : rd_reg

	// Stop, clear flag, then restart from reload and time the first overflow
	task automatic measure(input logic [7:0] r, input logic [2:0] sel);
		wr_reg(arpt_pkg::OFF_CSR, 8'h02);
		rd_reg(arpt_pkg::OFF_CSR, got);
		chk("irq after status read", 16'h0000, {15'h0000, irq_ff});
		wr_reg(arpt_pkg::OFF_ARR, r);
		wr_reg(arpt_pkg::OFF_CSR, {1'h0, sel, 4'hE});
		n = 0;
		while (irq_ff !== 1'h1 && n < 40000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("overflow cycles", 16'((256 - r) << sel), 16'(n));
		chk("pwm levels", 16'h000A, {12'h000, pwm_out});
	endtask : measure

	task automatic give_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#400000;
		fails++;
		$display("[FAIL] watchdog expected finish seen timeout");
		give_verdict();
	end

	initial begin
		rst_b = 1'h0;
		bus = '0;
		ext_clk_in = 1'h0;
		fails = 0;
		compares = 0;
		rows = '{'{1'h0, 3'h0, 8'h00, 8'h00}, '{1'h0, 3'h1, 8'h00, 8'h00},
			'{1'h0, 3'h2, 8'h00, 8'h00}, '{1'h0, 3'h3, 8'h00, 8'h00},
			'{1'h1, 3'h2, 8'hA5, 8'hA5}, '{1'h1, 3'h3, 8'hFA, 8'h0A},
			'{1'h1, 3'h5, 8'h77, 8'h00}, '{1'h1, 3'h0, 8'h57, 8'h52},
			'{1'h0, 3'h1, 8'h00, 8'hA5}, '{1'h1, 3'h1, 8'h3C, 8'h3C},
			'{1'h1, 3'h0, 8'h00, 8'h00}};
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr_reg(rows[i].a, rows[i].d);
			end
			rd_reg(rows[i].a, got);
			chk("register row", {8'h00, rows[i].e}, {8'h00, got});
		end
		$display("test register table done");
		for (int s = 0; s < 8; s++) begin
			measure(8'hF8, 3'(s));
		end
		measure(8'h00, 3'h0);
		$display("test period and divider done");
		// Overflow with interrupt disabled
		wr_reg(arpt_pkg::OFF_ARR, 8'hFC);
		wr_reg(arpt_pkg::OFF_CSR, 8'h02);
		rd_reg(arpt_pkg::OFF_CSR, got);
		wr_reg(arpt_pkg::OFF_CSR, 8'h0C);
		repeat (10) @(posedge clk);
		#1;
		chk("irq masked", 16'h0000, {15'h0000, irq_ff});
		rd_reg(arpt_pkg::OFF_CSR, got);
		chk("status with flag", 16'h0009, {8'h00, got});
		wr_reg(arpt_pkg::OFF_CSR, 8'h04);
		repeat (20) @(posedge clk);
		rd_reg(arpt_pkg::OFF_CAR, got);
		chk("frozen count", 16'h00FC, {8'h00, got});
		@(posedge clk);
		#1;
		chk("read data one cycle", 16'h0000, {8'h00, rdata_ff});
		wr_reg(arpt_pkg::OFF_CSR, 8'h78);
		wr_reg(arpt_pkg::OFF_CAR, 8'h10);
		rd_reg(arpt_pkg::OFF_CAR, got);
		chk("count written on the fly", 16'h0010, {8'h00, got});
		$display("test mask freeze and live count done");
		// External clock: only its rising edges are ticks
		wr_reg(arpt_pkg::OFF_CSR, 8'h02);
		rd_reg(arpt_pkg::OFF_CSR, got);
		wr_reg(arpt_pkg::OFF_ARR, 8'hF8);
		wr_reg(arpt_pkg::OFF_PWM, 8'h05);
		wr_reg(arpt_pkg::OFF_CSR, 8'h8E);
		repeat (30) @(posedge clk);
		#1;
		chk("ext idle no overflow", 16'h0000, {15'h0000, irq_ff});
		repeat (7) begin
			@(posedge clk);
			ext_clk_in <= 1'h1;
			@(posedge clk);
			ext_clk_in <= 1'h0;
		end
		repeat (3) @(posedge clk);
		#1;
		chk("ext seven edges", 16'h0000, {15'h0000, irq_ff});
		chk("pwm held before wrap", 16'h000A, {12'h000, pwm_out});
		@(posedge clk);
		ext_clk_in <= 1'h1;
		repeat (3) @(posedge clk);
		#1;
		chk("ext eighth edge", 16'h0001, {15'h0000, irq_ff});
		chk("pwm new polarity", 16'h0005, {12'h000, pwm_out});
		$display("test external clock done");
		@(posedge clk);
		rst_b <= 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		#1;
		chk("outputs in reset", 16'h0000, {11'h000, irq_ff, pwm_out});
		for (int a = 0; a < 4; a++) begin
			rd_reg(3'(a), got);
			chk("register after reset", 16'h0000, {8'h00, got});
		end
		$display("test second reset done");
		give_verdict();
	end
endmodule : tb
`default_nettype wire
